// ==== rxsc_pkg.sv ====
// Constants and types of the receiver serial control block
package rxsc_pkg;

	// Frame layout
	localparam logic [4:0] HDR_BITS   = 5'h08;
	localparam logic [4:0] FRAME_BITS = 5'h10;

	// Command codes
	localparam logic [3:0] CMD_NOP    = 4'h0;
	localparam logic [3:0] CMD_WRITE  = 4'h1;
	localparam logic [3:0] CMD_READ   = 4'h2;
	localparam logic [3:0] CMD_MRESET = 4'h3;

	// Register addresses
	localparam logic [3:0] A_MODULE_POWER_ENABLES = 4'h0;
	localparam logic [3:0] A_DEVICE_OPTIONS       = 4'h1;
	localparam logic [3:0] A_GAIN_TRACK_CAL_CTRL  = 4'h2;
	localparam logic [3:0] A_CRYSTAL_DIVISOR      = 4'h3;
	localparam logic [3:0] A_SLEEP_INTERVAL_HIGH  = 4'h4;
	localparam logic [3:0] A_SLEEP_INTERVAL_LOW   = 4'h5;
	localparam logic [3:0] A_HOST_WAKE_INTERVAL   = 4'h6;
	localparam logic [3:0] A_RADIO_SETTLE_HIGH    = 4'h7;
	localparam logic [3:0] A_RADIO_SETTLE_LOW     = 4'h8;
	localparam logic [3:0] A_RECEIVER_STATE_FLAGS = 4'h9;
	localparam logic [3:0] A_GAIN_HOLD_TIME       = 4'ha;
	localparam int         NUM_REGS               = 11;

	// Field positions
	localparam int PWR_SLEEP    = 0;
	localparam int PWR_ASK_PEAK = 1;
	localparam int PWR_FSK_PEAK = 3;
	localparam int OPT_DUTY     = 0;
	localparam int OPT_PS0      = 1;
	localparam int OPT_PS1      = 2;
	localparam int OPT_ASK_SEL  = 3;
	localparam int OPT_FSK_SEL  = 4;
	localparam int CTL_GAIN_LCK = 6;
	localparam int ST_PLL_LOCK  = 7;
	localparam int ST_HIGH_GAIN = 6;
	localparam int ST_CLK_ALIVE = 5;

	// Reset values
	localparam logic [7:0] RST_ZERO    = 8'h00;
	localparam logic [7:0] RST_OPTIONS = 8'h40;
	localparam logic [7:0] RST_DWELL   = 8'h0d;

	// Timer figures, counted in internal 100 kHz ticks
	localparam int TICK_HZ      = 100_000;
	localparam int TICK_US      = 1_000_000 / TICK_HZ;
	localparam int HOST_STEP_US = 120;
	localparam int SETTLE_US    = 10;
	localparam int OFF_BASE0_US = 120;
	localparam int OFF_BASE1_US = 480;
	localparam int OFF_BASE2_US = 1920;
	localparam int OFF_BASE3_US = 7680;

	typedef logic [25:0] rxsc_tmr_t;
	localparam rxsc_tmr_t HOST_STEP_TICKS = rxsc_tmr_t'(HOST_STEP_US / TICK_US);
	localparam rxsc_tmr_t SETTLE_TICKS    = rxsc_tmr_t'(SETTLE_US / TICK_US);
	localparam rxsc_tmr_t OFF_BASE0_TICKS = rxsc_tmr_t'(OFF_BASE0_US / TICK_US);
	localparam rxsc_tmr_t OFF_BASE1_TICKS = rxsc_tmr_t'(OFF_BASE1_US / TICK_US);
	localparam rxsc_tmr_t OFF_BASE2_TICKS = rxsc_tmr_t'(OFF_BASE2_US / TICK_US);
	localparam rxsc_tmr_t OFF_BASE3_TICKS = rxsc_tmr_t'(OFF_BASE3_US / TICK_US);

	// Duty-cycled receive sequencer states
	typedef enum logic [4:0] {
		duty_idle   = 5'h01,
		duty_off    = 5'h02,
		duty_host   = 5'h04,
		duty_settle = 5'h08,
		duty_rx     = 5'h10
	} rxsc_duty_t;

	typedef logic [NUM_REGS-1:0][7:0] rxsc_regs_t;

endpackage : rxsc_pkg

// ==== rxsc_tick_if.sv ====
// Interface between control block and its tick divider
`timescale 1ns/10ps
interface rxsc_tick_if;
	logic [7:0] divisor;
	logic       xtal_edge;
	logic       tick;

	modport gen  (input divisor, input xtal_edge, output tick);
	modport user (output divisor, output xtal_edge, input tick);
endinterface : rxsc_tick_if

// ==== rxsc_tick.sv ====
// Crystal divider that yields the internal 100 kHz tick
`timescale 1ns/10ps
module rxsc_tick (
	// Clock and reset
	input  wire logic  clock,
	input  wire logic  rst,
	// Divisor in, tick out
	rxsc_tick_if.gen   tif
);

	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} rxsc_tick_st_t;

	rxsc_tick_st_t s_r;
	rxsc_tick_st_t s_nxt;

	// Count crystal edges up to the divisor
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (tif.xtal_edge)
		begin
			if (tif.divisor == 8'h00)
				s_nxt.cnt = 8'h00;
			else if (s_r.cnt >= tif.divisor - 8'h01)
			begin
				s_nxt.cnt = 8'h00;
				s_nxt.tick = 1'b1;
			end
			else
				s_nxt.cnt = s_r.cnt + 8'h01;
		end
	end

	// State register
	always_ff @(posedge clock)
	begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign tif.tick = s_r.tick;

endmodule : rxsc_tick

// ==== rxsc_ctrl.sv ====
// Serial control port, register bank and duty-cycle sequencer
//
// Function
// - Three-line default and four-line wiring both supported
// - Input bits sampled on shift clock rising edge
// - Frame is command, address, data, MSB first
// - Decode nop, write, read, master reset commands
// - Readback select bits route data to pins
// - No select bit means bidirectional data line
// - Three-line read data returned next select cycle
// - Master reset held while select stays high
// - Power bits enable modules, sleep overrides them except in settle and receive
// - Divisor register divides crystal to 100 kHz
// - Sequence starts when select and line high
// - Device pulls line low after off interval
// - Settle powers radio, peaks and outputs off
// - Host release restarts the off interval
// - Low gain held two-power-dwell crystal cycles
// - Gain dwell resets to 0x0d
// - Registers are eight bits wide
// - Off count is 16 bits times prescale base
// - Host wake interval is count times 120 us
`timescale 1ns/10ps
module rxsc_ctrl (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// Serial port pins
	input  wire logic       shift_clk_pin,
	input  wire logic       cs_n_pin,
	input  wire logic       bidir_serial_line_i,
	output logic            bidir_serial_line_o,
	output logic            bidir_serial_line_oe,
	// Receiver side inputs
	input  wire logic       xtal_ref_in,
	input  wire logic       ask_demod_in,
	input  wire logic       fsk_demod_in,
	input  wire logic       power_below_in,
	input  wire logic       pll_lock_in,
	// Receiver side outputs
	output logic            ask_data_pin,
	output logic            fsk_data_pin,
	output logic [6:0]      module_enables,
	output logic            lna_high_gain
);

	typedef struct packed {
		logic [2:0]           sclk_s;
		logic [2:0]           cs_s;
		logic [1:0]           line_s;
		logic [2:0]           xtal_s;
		logic [1:0]           below_s;
		logic [1:0]           lock_s;
		logic [1:0]           ask_s;
		logic [1:0]           fsk_s;
		logic [15:0]          shreg;
		logic [4:0]           nbits;
		logic [7:0]           hdr;
		logic [7:0]           rd_shift;
		logic                 rd_skip;
		logic                 rd_pend;
		logic                 rd_cycle;
		logic                 rb_active;
		logic                 mreset;
		rxsc_pkg::rxsc_regs_t regs;
		rxsc_pkg::rxsc_duty_t state;
		rxsc_pkg::rxsc_tmr_t  tmr;
		logic                 acked;
		logic                 high_gain;
		logic [31:0]          dwell_cnt;
		logic                 clk_alive;
		logic                 line_out;
		logic                 line_oe;
		logic                 ask_pin;
		logic                 fsk_pin;
		logic [6:0]           en;
	} rxsc_ctrl_st_t;

	rxsc_ctrl_st_t s_r;
	rxsc_ctrl_st_t s_nxt;

	logic       sclk_rise;
	logic       sclk_fall;
	logic       cs_hi;
	logic       cs_fall;
	logic       cs_rise;
	logic       line_hi;
	logic       xtal_rise;
	logic       four_wire;
	logic       duty_on;
	logic [7:0] status;

	rxsc_tick_if tif ();

	// Power-on contents of the register bank
	function automatic rxsc_pkg::rxsc_regs_t regs_reset();
		rxsc_pkg::rxsc_regs_t r;
		r = '{default: rxsc_pkg::RST_ZERO};
		r[rxsc_pkg::A_DEVICE_OPTIONS] = rxsc_pkg::RST_OPTIONS;
		r[rxsc_pkg::A_GAIN_HOLD_TIME] = rxsc_pkg::RST_DWELL;
		return r;
	endfunction : regs_reset

	// Off interval length in ticks
	function automatic rxsc_pkg::rxsc_tmr_t off_ticks(
		input rxsc_pkg::rxsc_regs_t r
	);
		rxsc_pkg::rxsc_tmr_t base;
		rxsc_pkg::rxsc_tmr_t cnt;
		cnt = rxsc_pkg::rxsc_tmr_t'({r[rxsc_pkg::A_SLEEP_INTERVAL_HIGH],
			r[rxsc_pkg::A_SLEEP_INTERVAL_LOW]});
		case ({r[rxsc_pkg::A_DEVICE_OPTIONS][rxsc_pkg::OPT_PS1],
			r[rxsc_pkg::A_DEVICE_OPTIONS][rxsc_pkg::OPT_PS0]})
			2'b00:   base = rxsc_pkg::OFF_BASE0_TICKS;
			2'b01:   base = rxsc_pkg::OFF_BASE1_TICKS;
			2'b10:   base = rxsc_pkg::OFF_BASE2_TICKS;
			default: base = rxsc_pkg::OFF_BASE3_TICKS;
		endcase
		return rxsc_pkg::rxsc_tmr_t'(cnt * base);
	endfunction : off_ticks

	// Register read mux; unmapped addresses read zero
	function automatic logic [7:0] reg_read(
		input rxsc_pkg::rxsc_regs_t r,
		input logic [7:0]           st,
		input logic [3:0]           addr
	);
		logic [7:0] v;
		v = 8'h00;
		if (addr == rxsc_pkg::A_RECEIVER_STATE_FLAGS)
			v = st;
		else if (int'(addr) < rxsc_pkg::NUM_REGS)
			v = r[addr];
		return v;
	endfunction : reg_read

	// Edge and level views of synchronised pins
	assign sclk_rise = s_r.sclk_s[1] & ~s_r.sclk_s[2];
	assign sclk_fall = ~s_r.sclk_s[1] & s_r.sclk_s[2];
	assign cs_hi     = s_r.cs_s[1];
	assign cs_fall   = ~s_r.cs_s[1] & s_r.cs_s[2];
	assign cs_rise   = s_r.cs_s[1] & ~s_r.cs_s[2];
	assign line_hi   = s_r.line_s[1];
	assign xtal_rise = s_r.xtal_s[1] & ~s_r.xtal_s[2];
	assign four_wire = s_r.regs[rxsc_pkg::A_DEVICE_OPTIONS][rxsc_pkg::OPT_ASK_SEL]
		| s_r.regs[rxsc_pkg::A_DEVICE_OPTIONS][rxsc_pkg::OPT_FSK_SEL];
	assign duty_on   = s_r.regs[rxsc_pkg::A_DEVICE_OPTIONS][rxsc_pkg::OPT_DUTY];
	assign status    = {s_r.lock_s[1], s_r.high_gain, s_r.clk_alive, 5'h00};

	// Tick divider hookup
	assign tif.divisor   = s_r.regs[rxsc_pkg::A_CRYSTAL_DIVISOR];
	assign tif.xtal_edge = xtal_rise;

	rxsc_tick u_tick (
		.clock (clock),
		.rst   (rst),
		.tif   (tif.gen)
	);

	// Next-state logic of the whole block
	always_comb
	begin
		logic [7:0] opt;
		logic [7:0] pwr;
		logic       data_en;
		opt = 8'h00;
		pwr = 8'h00;
		data_en = 1'b0;
		s_nxt = s_r;

		// Two-flop synchronisers
		s_nxt.sclk_s  = {s_r.sclk_s[1:0], shift_clk_pin};
		s_nxt.cs_s    = {s_r.cs_s[1:0], cs_n_pin};
		s_nxt.line_s  = {s_r.line_s[0], bidir_serial_line_i};
		s_nxt.xtal_s  = {s_r.xtal_s[1:0], xtal_ref_in};
		s_nxt.below_s = {s_r.below_s[0], power_below_in};
		s_nxt.lock_s  = {s_r.lock_s[0], pll_lock_in};
		s_nxt.ask_s   = {s_r.ask_s[0], ask_demod_in};
		s_nxt.fsk_s   = {s_r.fsk_s[0], fsk_demod_in};

		// Serial frame handling
		if (cs_fall)
		begin
			s_nxt.nbits = 5'h00;
			s_nxt.hdr = {rxsc_pkg::CMD_NOP, 4'h0};
			s_nxt.rb_active = 1'b0;
			s_nxt.mreset = 1'b0;
			if (s_r.rd_pend)
			begin
				s_nxt.rd_pend = 1'b0;
				s_nxt.rd_cycle = 1'b1;
				s_nxt.rd_skip = 1'b0;
			end
		end
		else if (cs_rise)
		begin
			s_nxt.rb_active = 1'b0;
			if (s_r.rd_cycle)
				s_nxt.rd_cycle = 1'b0;
			else if (s_r.nbits >= rxsc_pkg::HDR_BITS && !four_wire
				&& s_r.hdr[7:4] == rxsc_pkg::CMD_READ)
				s_nxt.rd_pend = 1'b1;
			if (!s_r.rd_cycle && s_r.nbits >= rxsc_pkg::HDR_BITS
				&& s_r.hdr[7:4] == rxsc_pkg::CMD_MRESET)
				s_nxt.mreset = 1'b1;
		end
		else if (!cs_hi)
		begin
			// Shift in on rising clock, command then address then data
			if (sclk_rise && !s_r.rd_cycle && s_r.nbits < rxsc_pkg::FRAME_BITS)
			begin
				s_nxt.shreg = {s_r.shreg[14:0], line_hi};
				s_nxt.nbits = s_r.nbits + 5'h01;
				if (s_r.nbits == rxsc_pkg::HDR_BITS - 5'h01)
				begin
					s_nxt.hdr = s_nxt.shreg[7:0];
					if (s_nxt.shreg[7:4] == rxsc_pkg::CMD_READ)
					begin
						s_nxt.rd_shift = reg_read(s_r.regs, status,
							s_nxt.shreg[3:0]);
						s_nxt.rd_skip = 1'b1;
						s_nxt.rb_active = four_wire;
					end
				end
				if (s_r.nbits == rxsc_pkg::FRAME_BITS - 5'h01
					&& s_r.hdr[7:4] == rxsc_pkg::CMD_WRITE
					&& s_r.hdr[3:0] != rxsc_pkg::A_RECEIVER_STATE_FLAGS
					&& int'(s_r.hdr[3:0]) < rxsc_pkg::NUM_REGS)
					s_nxt.regs[s_r.hdr[3:0]] = s_nxt.shreg[7:0];
			end
			// Shift out on falling clock so the bit is stable at the rise
			if (sclk_fall && (s_r.rd_cycle || s_r.rb_active))
			begin
				if (s_r.rd_skip)
					s_nxt.rd_skip = 1'b0;
				else
					s_nxt.rd_shift = {s_r.rd_shift[6:0], 1'b0};
			end
		end

		// Duty-cycled receive sequencer
		case (s_r.state)
			rxsc_pkg::duty_idle:
				if (cs_hi && line_hi && !s_r.mreset)
				begin
					s_nxt.state = rxsc_pkg::duty_off;
					s_nxt.tmr = off_ticks(s_r.regs);
				end
			rxsc_pkg::duty_off:
				if (tif.tick)
				begin
					if (s_r.tmr <= rxsc_pkg::rxsc_tmr_t'(1))
					begin
						s_nxt.state = rxsc_pkg::duty_host;
						s_nxt.tmr = rxsc_pkg::rxsc_tmr_t'(
							s_r.regs[rxsc_pkg::A_HOST_WAKE_INTERVAL]
							* rxsc_pkg::HOST_STEP_TICKS);
					end
					else
						s_nxt.tmr = s_r.tmr - rxsc_pkg::rxsc_tmr_t'(1);
				end
			rxsc_pkg::duty_host:
				if (tif.tick)
				begin
					if (s_r.tmr <= rxsc_pkg::rxsc_tmr_t'(1))
					begin
						s_nxt.state = rxsc_pkg::duty_settle;
						s_nxt.acked = 1'b0;
						s_nxt.tmr = rxsc_pkg::rxsc_tmr_t'(
							{s_r.regs[rxsc_pkg::A_RADIO_SETTLE_HIGH],
							s_r.regs[rxsc_pkg::A_RADIO_SETTLE_LOW]}
							* rxsc_pkg::SETTLE_TICKS);
					end
					else
						s_nxt.tmr = s_r.tmr - rxsc_pkg::rxsc_tmr_t'(1);
				end
			rxsc_pkg::duty_settle:
				if (tif.tick)
				begin
					if (!line_hi)
						s_nxt.acked = 1'b1;
					if (s_r.tmr <= rxsc_pkg::rxsc_tmr_t'(1))
					begin
						if (s_r.acked || !line_hi)
							s_nxt.state = rxsc_pkg::duty_rx;
						else
						begin
							s_nxt.state = rxsc_pkg::duty_off;
							s_nxt.tmr = off_ticks(s_r.regs);
						end
					end
					else
						s_nxt.tmr = s_r.tmr - rxsc_pkg::rxsc_tmr_t'(1);
				end
			rxsc_pkg::duty_rx:
				if (line_hi)
				begin
					s_nxt.state = rxsc_pkg::duty_off;
					s_nxt.tmr = off_ticks(s_r.regs);
				end
			default:
				s_nxt.state = rxsc_pkg::duty_idle;
		endcase
		if (!duty_on || !cs_hi)
			s_nxt.state = rxsc_pkg::duty_idle;

		// Gain dwell: fast drop to low gain, timed return to high gain
		if (!s_r.regs[rxsc_pkg::A_GAIN_TRACK_CAL_CTRL][rxsc_pkg::CTL_GAIN_LCK])
		begin
			if (!s_r.below_s[1])
			begin
				s_nxt.high_gain = 1'b0;
				s_nxt.dwell_cnt = 32'h0;
			end
			else if (!s_r.high_gain && xtal_rise)
			begin
				if (s_r.dwell_cnt >= (32'h1 <<
					s_r.regs[rxsc_pkg::A_GAIN_HOLD_TIME][4:0]) - 32'h1)
				begin
					s_nxt.high_gain = 1'b1;
					s_nxt.dwell_cnt = 32'h0;
				end
				else
					s_nxt.dwell_cnt = s_r.dwell_cnt + 32'h1;
			end
		end
		if (xtal_rise)
			s_nxt.clk_alive = 1'b1;

		// Master reset returns the bank to power-on contents
		if (s_r.mreset)
		begin
			s_nxt.regs = regs_reset();
			s_nxt.rd_pend = 1'b0;
			s_nxt.state = rxsc_pkg::duty_idle;
			s_nxt.high_gain = 1'b1;
			s_nxt.dwell_cnt = 32'h0;
			s_nxt.clk_alive = 1'b0;
		end

		// Pin and enable outputs
		opt = s_nxt.regs[rxsc_pkg::A_DEVICE_OPTIONS];
		pwr = s_r.regs[rxsc_pkg::A_MODULE_POWER_ENABLES];
		s_nxt.line_oe = s_nxt.rd_cycle
			| (s_nxt.state == rxsc_pkg::duty_host);
		s_nxt.line_out = s_nxt.rd_cycle & s_nxt.rd_shift[7];
		case (s_nxt.state)
			rxsc_pkg::duty_off, rxsc_pkg::duty_host:
			begin
				s_nxt.en = 7'h00;
				data_en = 1'b0;
			end
			rxsc_pkg::duty_settle:
			begin
				s_nxt.en = pwr[7:1] & ~7'h05;
				data_en = 1'b0;
			end
			rxsc_pkg::duty_rx:
			begin
				s_nxt.en = pwr[7:1];
				data_en = 1'b1;
			end
			default:
			begin
				s_nxt.en = pwr[rxsc_pkg::PWR_SLEEP] ? 7'h00 : pwr[7:1];
				data_en = !pwr[rxsc_pkg::PWR_SLEEP] && !duty_on;
			end
		endcase
		s_nxt.ask_pin = (s_nxt.rb_active && opt[rxsc_pkg::OPT_ASK_SEL])
			? s_nxt.rd_shift[7] : (data_en & s_r.ask_s[1]);
		s_nxt.fsk_pin = (s_nxt.rb_active && opt[rxsc_pkg::OPT_FSK_SEL])
			? s_nxt.rd_shift[7] : (data_en & s_r.fsk_s[1]);
	end

	// State register
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			s_r <= '0;
			s_r.regs <= regs_reset();
			s_r.state <= rxsc_pkg::duty_idle;
			s_r.high_gain <= 1'b1;
			s_r.cs_s <= '1; // Deselected level, no false select edge
			s_r.below_s <= '1; // Matches high gain, no false drop
		end
		else
			s_r <= s_nxt;
	end

	// Outputs straight from flip-flops
	assign bidir_serial_line_o  = s_r.line_out;
	assign bidir_serial_line_oe = s_r.line_oe;
	assign ask_data_pin         = s_r.ask_pin;
	assign fsk_data_pin         = s_r.fsk_pin;
	assign module_enables       = s_r.en;
	assign lna_high_gain        = s_r.high_gain;

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_wake_low;
		s_r.state == rxsc_pkg::duty_host |-> s_r.line_oe && !s_r.line_out;
	endproperty
	a_wake_low: assert property (p_wake_low)
		else $error("line not pulled low in host wake interval");

	property p_settle_mask;
		s_r.state == rxsc_pkg::duty_settle |->
			!s_r.en[0] && !s_r.en[2] && !s_r.ask_pin && !s_r.fsk_pin;
	endproperty
	a_settle_mask: assert property (p_settle_mask)
		else $error("peaks or data outputs on during settle");

	property p_seq_start;
		s_r.state == rxsc_pkg::duty_off
		&& $past(s_r.state) == rxsc_pkg::duty_idle
		|-> $past(s_r.cs_s[1]) && $past(s_r.line_s[1]);
	endproperty
	a_seq_start: assert property (p_seq_start)
		else $error("sequence began without select and line high");

	property p_rx_release;
		s_r.state == rxsc_pkg::duty_rx && line_hi && cs_hi && duty_on
		&& !s_r.mreset |=> s_r.state == rxsc_pkg::duty_off;
	endproperty
	a_rx_release: assert property (p_rx_release)
		else $error("line release did not restart off interval");

	property p_mreset_hold;
		s_r.mreset && cs_hi && !cs_fall |=> s_r.mreset
			&& s_r.regs[rxsc_pkg::A_GAIN_HOLD_TIME] == 8'h0d
			&& s_r.regs[rxsc_pkg::A_MODULE_POWER_ENABLES] == 8'h00;
	endproperty
	a_mreset_hold: assert property (p_mreset_hold)
		else $error("master reset dropped or bank not cleared");

	property p_dwell_reset;
		$fell(rst) |-> s_r.regs[rxsc_pkg::A_GAIN_HOLD_TIME] == 8'h0d;
	endproperty
	a_dwell_reset: assert property (p_dwell_reset)
		else $error("gain dwell not 0x0d after reset");

	property p_sleep;
		!duty_on && s_r.regs[rxsc_pkg::A_MODULE_POWER_ENABLES][0]
		&& !s_r.mreset |=> s_r.en == 7'h00;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep bit did not force enables off");

	property p_read3;
		s_r.rd_pend && cs_fall |=> s_r.line_oe [*2];
	endproperty
	a_read3: assert property (p_read3)
		else $error("three-line read cycle did not drive line");

	property p_four_rb;
		s_r.rb_active && s_r.regs[rxsc_pkg::A_DEVICE_OPTIONS][3]
		|-> s_r.ask_pin == s_r.rd_shift[7] && !s_r.line_oe;
	endproperty
	a_four_rb: assert property (p_four_rb)
		else $error("four-line readback not on pin");

	property p_gain_drop;
		!s_r.regs[rxsc_pkg::A_GAIN_TRACK_CAL_CTRL][6] && !s_r.below_s[1]
		&& !s_r.mreset |=> !s_r.high_gain;
	endproperty
	a_gain_drop: assert property (p_gain_drop)
		else $error("gain not low while power above threshold");

	property p_no_write;
		!cs_hi && !cs_rise && !cs_fall && sclk_rise && !s_r.rd_cycle
		&& s_r.nbits == 5'h0f && s_r.hdr[7:4] != 4'h1 && !s_r.mreset
		|=> $stable(s_r.regs);
	endproperty
	a_no_write: assert property (p_no_write)
		else $error("register changed on non-write frame");

	c_read3: cover property (s_r.rd_cycle && sclk_fall);
	c_mreset: cover property (s_r.mreset);
	c_rx: cover property (s_r.state == rxsc_pkg::duty_rx);
	c_restart: cover property (s_r.state == rxsc_pkg::duty_settle
		##1 s_r.state == rxsc_pkg::duty_off);

endmodule : rxsc_ctrl

// ==== rxsc_host_model.sv ====
// Host controller model acting as serial master of the control port
`timescale 1ns/10ps
module rxsc_host_model (
	// Clock
	input  wire logic clock,
	// Device side of the pins
	input  wire logic dev_o,
	input  wire logic dev_oe,
	input  wire logic ask_pin,
	input  wire logic fsk_pin,
	// Host driven pins
	output logic      sclk,
	output logic      cs_n,
	output logic      line
);
	logic host_oe;
	logic host_d;
	logic rb_fsk; // Which data pin carries four-line readback

	// Resolved data line, pull-up when nobody drives
	assign line = dev_oe ? dev_o : (host_oe ? host_d : 1'b1);

	// Idle pins: deselected, line held low
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		host_oe = 1'b1;
		host_d = 1'b0;
		rb_fsk = 1'b0;
	end

	task wait_n(input int n);
		repeat (n) @(posedge clock);
	endtask : wait_n

	// One select cycle of n shift clocks; collects line and pin bits
	task frame(input logic [15:0] w, input int n, input logic drive,
		output logic [7:0] rl, output logic [7:0] ra);
		cs_n <= 1'b0;
		host_oe <= drive;
		wait_n(6);
		for (int i = 0; i < n; i++)
		begin
			host_d <= w[15-i];
			wait_n(5);
			sclk <= 1'b1;
			rl = {rl[6:0], line};
			ra = {ra[6:0], rb_fsk ? fsk_pin : ask_pin};
			wait_n(5);
			sclk <= 1'b0;
		end
		wait_n(2);
		cs_n <= 1'b1;
		host_oe <= 1'b1;
		host_d <= 1'b0;
		wait_n(8);
	endtask : frame
endmodule : rxsc_host_model

// ==== test_rx_serial_control_drx.sv ====
// Self-checking testbench of the receiver serial control block
`timescale 1ns/10ps
module test_rx_serial_control_drx;
	logic       clock;
	logic       rst;
	logic       sclk;
	logic       cs_n;
	logic       line;
	logic       dev_o;
	logic       dev_oe;
	logic       xtal;
	logic       pwr_below;
	logic       ask_dm;
	logic       fsk_dm;
	logic       lock;
	logic       fsk_pin;
	logic       ask_pin;
	logic       lna;
	logic [6:0] en;
	logic [7:0] rl;
	logic [7:0] ra;
	logic [7:0] v;
	int         errors;
	int         check_count;
	int         cycles;
	int         n;

	rxsc_ctrl dut (
		.clock(clock), .rst(rst), .shift_clk_pin(sclk), .cs_n_pin(cs_n),
		.bidir_serial_line_i(line), .bidir_serial_line_o(dev_o),
		.bidir_serial_line_oe(dev_oe), .xtal_ref_in(xtal),
		.ask_demod_in(ask_dm), .fsk_demod_in(fsk_dm),
		.power_below_in(pwr_below), .pll_lock_in(lock),
		.ask_data_pin(ask_pin), .fsk_data_pin(fsk_pin), .module_enables(en),
		.lna_high_gain(lna)
	);

	rxsc_host_model host (
		.clock(clock), .dev_o(dev_o), .dev_oe(dev_oe), .ask_pin(ask_pin),
		.fsk_pin(fsk_pin), .sclk(sclk), .cs_n(cs_n), .line(line)
	);

	// Clocks: 50 MHz system, 5 MHz crystal
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial
	begin
		xtal = 1'b0;
		forever
		begin
			repeat (5) @(posedge clock);
			xtal <= ~xtal;
		end
	end

	task conclude;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	// Hang guard
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			errors++;
			conclude();
		end
	end

	task check(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task wr(input logic [3:0] a, input logic [7:0] d);
		host.frame({rxsc_pkg::CMD_WRITE, a, d}, 16, 1'b1, rl, ra);
	endtask : wr

	// Three-line read, eight clocks in the return cycle
	task rd(input logic [3:0] a, output logic [7:0] d);
		host.frame({rxsc_pkg::CMD_READ, a, 8'h00}, 8, 1'b1, rl, ra);
		host.frame(16'h0000, 8, 1'b0, rl, ra);
		d = rl;
	endtask : rd

	task t_reset;
		for (int a = 0; a < 11; a++)
		begin
			rd(4'(a), v);
			if (a != 9)
				check("reset", a == 1 ? 8'h40 : (a == 10 ? 8'h0d : 8'h00), v);
		end
		rd(4'h9, v);
		check("status", 8'h60, v);
	endtask : t_reset

	task t_rw;
		for (int a = 0; a < 11; a++)
		begin
			if (a != 1 && a != 9)
			begin
				wr(4'(a), {4'(a), ~4'(a)});
				rd(4'(a), v);
				check("rw", {4'(a), ~4'(a)}, v);
			end
		end
	endtask : t_rw

	task t_ignored;
		lock <= 1'b1;
		wr(4'h5, 8'h5a);
		for (int c = 0; c < 16; c++)
			if (c == 0 || c > 3)
				host.frame({4'(c), 4'h5, 8'ha5}, 16, 1'b1, rl, ra);
		host.frame({rxsc_pkg::CMD_WRITE, 4'h5, 8'hff}, 12, 1'b1, rl, ra);
		wr(4'h9, 8'h1f);
		rd(4'h5, v);
		check("ignored", 8'h5a, v);
		rd(4'h9, v);
		check("status ro", 8'he0, v);
	endtask : t_ignored

	task t_power;
		wr(4'h0, 8'hfe);
		check("enables", 8'h7f, {1'b0, en});
		ask_dm <= 1'b1;
		host.wait_n(5);
		check("ask data", 8'h02, {6'h00, ask_pin, fsk_pin});
		ask_dm <= 1'b0;
		fsk_dm <= 1'b1;
		host.wait_n(5);
		check("fsk data", 8'h01, {6'h00, ask_pin, fsk_pin});
		wr(4'h0, 8'hff);
		check("sleep", 8'h00, {1'b0, en});
		check("sleep data", 8'h00, {6'h00, ask_pin, fsk_pin});
	endtask : t_power

	task t_gain;
		wr(4'ha, 8'h02);
		pwr_below <= 1'b0;
		host.wait_n(10);
		check("low gain", 8'h00, {7'h00, lna});
		pwr_below <= 1'b1;
		host.wait_n(10);
		check("dwell", 8'h00, {7'h00, lna});
		host.wait_n(60);
		check("high gain", 8'h01, {7'h00, lna});
		wr(4'h2, 8'h40);
		pwr_below <= 1'b0;
		host.wait_n(10);
		check("gain lock", 8'h01, {7'h00, lna});
		pwr_below <= 1'b1;
		wr(4'h2, 8'h00);
	endtask : t_gain

	task t_mreset;
		host.frame({rxsc_pkg::CMD_MRESET, 4'h0, 8'h00}, 16, 1'b1, rl, ra);
		rd(4'ha, v);
		check("mreset dwell", 8'h0d, v);
		rd(4'h0, v);
		check("mreset power", 8'h00, v);
	endtask : t_mreset

	task t_four;
		wr(4'h6, 8'hc3);
		wr(4'h1, 8'h08);
		host.frame({rxsc_pkg::CMD_READ, 4'h6, 8'h00}, 16, 1'b1, rl, ra);
		check("four line", 8'hc3, ra);
		wr(4'h1, 8'h10);
		host.rb_fsk <= 1'b1;
		host.frame({rxsc_pkg::CMD_READ, 4'h6, 8'h00}, 16, 1'b1, rl, ra);
		check("four line fsk", 8'hc3, ra);
		host.rb_fsk <= 1'b0;
		wr(4'h1, 8'h00);
	endtask : t_four

	task t_duty;
		ask_dm <= 1'b1;
		wr(4'h3, 8'h02);
		wr(4'h5, 8'h01);
		wr(4'h6, 8'h01);
		wr(4'h8, 8'h02);
		wr(4'h0, 8'hfe);
		wr(4'h1, 8'h01);
		host.wait_n(600);
		check("held off", 8'h00, {7'h00, dev_oe});
		host.host_oe <= 1'b0;
		for (n = 0; n < 3000 && !(dev_oe === 1'b1 && dev_o === 1'b0); n++)
			@(posedge clock);
		check("wake", 8'h01, {7'h00, n < 3000});
		host.host_oe <= 1'b1;
		for (n = 0; n < 3000 && en !== 7'h7f; n++)
			@(posedge clock);
		check("rx on", 8'h01, {7'h00, n < 3000});
		check("rx data", 8'h03, {6'h00, ask_pin, fsk_pin});
		host.host_oe <= 1'b0;
		host.wait_n(10);
		check("off again", 8'h00, {1'b0, en});
		for (n = 0; n < 3000 && dev_oe !== 1'b1; n++)
			@(posedge clock);
		check("rewake", 8'h01, {7'h00, n < 3000});
		for (n = 0; n < 3000 && dev_oe !== 1'b0; n++)
			@(posedge clock);
		host.wait_n(80);
		check("no ack", 8'h00, {1'b0, en});
		wr(4'h1, 8'h00);
	endtask : t_duty

	// Main sequence
	initial
	begin
		errors = 0;
		check_count = 0;
		cycles = 0;
		rst = 1'b1;
		pwr_below = 1'b1;
		ask_dm = 1'b0;
		fsk_dm = 1'b0;
		lock = 1'b0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		host.wait_n(5);
		t_reset();
		t_rw();
		t_ignored();
		t_power();
		t_gain();
		t_mreset();
		t_four();
		t_duty();
		conclude();
	end
endmodule : test_rx_serial_control_drx
